// ==== hdl/spsc_pkg.sv ====
// spsc_pkg: constants, carrier structs and helpers for the paging unit.
// assumes one system clock and a cpu core that issues one access a cycle.
package spsc_pkg;

    // widths and counts
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned NUM_PAGES  = 5;
    localparam int unsigned BANK_DEPTH = 64;
    localparam int unsigned NUM_PORTS  = 4;

    // register space boundaries
    localparam logic [7:0] SFR_BASE    = 8'h80;
    localparam logic [1:0] BANK_REGION = 2'b11;   // addr[7:6] of paged slots

    // registers that answer on every page
    localparam logic [7:0] ADDR_PAGE_SEL = 8'h84;
    localparam logic [7:0] ADDR_STK_MID  = 8'h85;
    localparam logic [7:0] ADDR_STK_BOT  = 8'h86;
    localparam logic [7:0] ADDR_PAGE_CTL = 8'h96;
    localparam logic [3:0] PORT_NIB      = 4'h0;  // ports at 0x80,90,a0,b0
    localparam logic [1:0] PORT_HI       = 2'b10; // addr[7:6] of port span

    // bit-addressable low nibbles
    localparam logic [3:0] NIB_BIT_A = 4'h0;
    localparam logic [3:0] NIB_BIT_B = 4'h8;

    // populated page numbers, in bank order
    localparam logic [7:0] PAGE_NUM [NUM_PAGES] =
        '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0F};

    // reset values and control field positions
    localparam logic [7:0] PAGE_SEL_RST = 8'h00;
    localparam logic [7:0] STK_RST      = 8'h00;
    localparam logic [7:0] EMPTY_PAGE   = 8'h00;
    localparam logic [7:0] PAGE_CTL_RST = 8'h01;
    localparam int unsigned AUTO_EN_BIT = 0;
    localparam logic [7:0] PAGE_CTL_MSK = 8'h01;  // reserved bits read 0
    localparam logic [7:0] RD_UNDEF     = 8'h00;

    // target of a decoded access
    typedef enum logic [6:0] {
        SPSC_TGT_NONE     = 7'b000_0001,
        SPSC_TGT_PAGE_SEL = 7'b000_0010,
        SPSC_TGT_STK_MID  = 7'b000_0100,
        SPSC_TGT_STK_BOT  = 7'b000_1000,
        SPSC_TGT_PAGE_CTL = 7'b001_0000,
        SPSC_TGT_PORT     = 7'b010_0000,
        SPSC_TGT_BANK     = 7'b100_0000
    } spsc_tgt_t;

    // cpu access: one strobe a cycle, bit data in wdata[0]
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
        logic       direct;
        logic       bit_op;
        logic [2:0] bit_idx;
    } spsc_cpu_req_t;

    // interrupt logic: one-cycle strobes plus target page
    typedef struct packed {
        logic       push;
        logic       pop;
        logic [7:0] page;
    } spsc_irq_t;

    // decoder result
    typedef struct packed {
        spsc_tgt_t  tgt;
        logic [2:0] bank;
        logic [5:0] slot;
        logic [1:0] port;
        logic       legal;
    } spsc_dec_t;

    // byte or single-bit update of a stored byte
    function automatic logic [7:0] spsc_merge(input logic [7:0] old,
                                              input logic [7:0] wd,
                                              input logic       bit_op,
                                              input logic [2:0] idx);
        logic [7:0] r;
        r = bit_op ? old : wd;
        if (bit_op) begin
            r[idx] = wd[0];
        end
        return r;
    endfunction : spsc_merge

endpackage : spsc_pkg

// ==== hdl/spsc_decode.sv ====
// spsc_decode: maps page and direct address onto a register target.
// assumes inputs stable within the cycle; purely combinational.
`timescale 1ns/1ps
module spsc_decode
    import spsc_pkg::*;
(
    input  wire logic [7:0]          page,
    input  wire spsc_pkg::spsc_cpu_req_t req,
    output spsc_pkg::spsc_dec_t      dec
);
    logic       hit;
    logic [2:0] bidx;
    logic       bit_ok;

    // find the bank that holds the selected page
    always_comb begin
        hit  = 1'b0;
        bidx = 3'd0;
        for (int i = 0; i < NUM_PAGES; i++) begin
            if (page == PAGE_NUM[i]) begin
                hit  = 1'b1;
                bidx = 3'(i);
            end
        end
    end

    assign bit_ok = !req.bit_op || req.addr[3:0] == NIB_BIT_A
                    || req.addr[3:0] == NIB_BIT_B;

    // all-pages registers first, then the paged bank slots
    always_comb begin
        dec       = '0;
        dec.tgt   = SPSC_TGT_NONE;
        dec.bank  = bidx;
        dec.slot  = req.addr[5:0];
        dec.port  = req.addr[5:4];
        if (req.addr == ADDR_PAGE_SEL) begin
            dec.tgt = SPSC_TGT_PAGE_SEL;
        end else if (req.addr == ADDR_STK_MID) begin
            dec.tgt = SPSC_TGT_STK_MID;
        end else if (req.addr == ADDR_STK_BOT) begin
            dec.tgt = SPSC_TGT_STK_BOT;
        end else if (req.addr == ADDR_PAGE_CTL) begin
            dec.tgt = SPSC_TGT_PAGE_CTL;
        end else if (req.addr[7:6] == PORT_HI
                     && req.addr[3:0] == PORT_NIB) begin
            dec.tgt = SPSC_TGT_PORT;
        end else if (req.addr[7:6] == BANK_REGION && hit) begin
            dec.tgt = SPSC_TGT_BANK;
        end
        dec.legal = req.direct && req.addr >= SFR_BASE
                    && dec.tgt != SPSC_TGT_NONE && bit_ok;
    end

endmodule : spsc_decode

// ==== hdl/spsc_page_unit.sv ====
// spsc_page_unit: register paging unit with a three-entry page stack.
// assumes the cpu issues at most one read or write strobe a cycle and the
// interrupt logic gives one-cycle push and pop strobes.
`timescale 1ns/1ps
module spsc_page_unit
    import spsc_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire spsc_pkg::spsc_cpu_req_t cpu_req,
    input  wire spsc_pkg::spsc_irq_t     irq,
    output logic [7:0]                   rdata,
    output logic                         access_fault,
    output logic [7:0]                   page_select_reg,
    output logic [7:0]                   page_stack_middle,
    output logic [7:0]                   page_stack_bottom,
    output logic                         auto_page_enable,
    output logic [NUM_PORTS-1:0][7:0]    port_out
);
    import spsc_pkg::*;

    // whole state of the unit
    typedef struct packed {
        logic [7:0]                            page;
        logic [7:0]                            mid;
        logic [7:0]                            bot;
        logic [7:0]                            ctl;
        logic [NUM_PORTS-1:0][7:0]             ports;
        logic [NUM_PAGES-1:0][BANK_DEPTH-1:0][7:0] bank;
        logic [7:0]                            rdata;
        logic                                  fault;
    } spsc_state_t;

    spsc_state_t s;
    spsc_state_t next_s;
    spsc_dec_t   dec;
    logic        auto_en;
    logic        push_go;
    logic        pop_go;
    logic        acc;
    logic [7:0]  rd_val;

    // decode against the page in force this cycle
    spsc_decode u_decode (
        .page (s.page),
        .req  (cpu_req),
        .dec  (dec)
    );

    // stack events are gated by the enable bit
    assign auto_en = s.ctl[AUTO_EN_BIT];
    assign push_go = irq.push && auto_en;
    assign pop_go  = irq.pop && auto_en;
    assign acc     = cpu_req.wr || cpu_req.rd;

    // read mux over the decoded target
    always_comb begin
        rd_val = RD_UNDEF;
        unique case (dec.tgt)
            SPSC_TGT_NONE:     rd_val = RD_UNDEF;
            SPSC_TGT_PAGE_SEL: rd_val = s.page;
            SPSC_TGT_STK_MID:  rd_val = s.mid;
            SPSC_TGT_STK_BOT:  rd_val = s.bot;
            SPSC_TGT_PAGE_CTL: rd_val = s.ctl & PAGE_CTL_MSK;
            SPSC_TGT_PORT:     rd_val = s.ports[dec.port];
            SPSC_TGT_BANK:     rd_val = s.bank[dec.bank][dec.slot];
        endcase
        if (!dec.legal) begin
            rd_val = RD_UNDEF;
        end
    end

    // next state: software access first, stack events override the stack
    always_comb begin
        next_s       = s;
        next_s.fault = cpu_req.direct && acc && !dec.legal
                       && cpu_req.addr >= SFR_BASE;
        next_s.rdata = cpu_req.rd ? rd_val : RD_UNDEF;
        if (cpu_req.wr && dec.legal) begin
            unique case (dec.tgt)
                SPSC_TGT_NONE: begin
                    next_s.page = s.page;
                end
                SPSC_TGT_PAGE_SEL: begin
                    next_s.page = spsc_merge(s.page, cpu_req.wdata,
                                             cpu_req.bit_op,
                                             cpu_req.bit_idx);
                end
                SPSC_TGT_STK_MID: begin
                    next_s.mid = cpu_req.wdata;
                end
                SPSC_TGT_STK_BOT: begin
                    next_s.bot = cpu_req.wdata;
                end
                SPSC_TGT_PAGE_CTL: begin
                    next_s.ctl = cpu_req.wdata & PAGE_CTL_MSK;
                end
                SPSC_TGT_PORT: begin
                    next_s.ports[dec.port] =
                        spsc_merge(s.ports[dec.port], cpu_req.wdata,
                                   cpu_req.bit_op, cpu_req.bit_idx);
                end
                SPSC_TGT_BANK: begin
                    next_s.bank[dec.bank][dec.slot] =
                        spsc_merge(s.bank[dec.bank][dec.slot],
                                   cpu_req.wdata, cpu_req.bit_op,
                                   cpu_req.bit_idx);
                end
            endcase
        end
        // return and new vector in one cycle: stack depth unchanged
        if (push_go && pop_go) begin
            next_s.page = irq.page;
            next_s.mid  = s.mid;
            next_s.bot  = s.bot;
        end else if (push_go) begin
            next_s.bot  = s.mid;
            next_s.mid  = s.page;
            next_s.page = irq.page;
        end else if (pop_go) begin
            next_s.page = s.mid;
            next_s.mid  = s.bot;
            next_s.bot  = EMPTY_PAGE;
        end
    end

    // register the whole state; memory slots clear at reset too
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s      <= '0;
            s.page <= PAGE_SEL_RST;
            s.mid  <= STK_RST;
            s.bot  <= STK_RST;
            s.ctl  <= PAGE_CTL_RST;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from state flops
    assign rdata             = s.rdata;
    assign access_fault      = s.fault;
    assign page_select_reg   = s.page;
    assign page_stack_middle = s.mid;
    assign page_stack_bottom = s.bot;
    assign auto_page_enable  = s.ctl[AUTO_EN_BIT];
    assign port_out          = s.ports;

    // checks on the paging and stack behaviour
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // enable bit is set in the first cycle after reset
    a_enable_after_reset: assert property (
        $past(!rst_n) |-> auto_page_enable)
        else $error("auto paging not enabled after reset");

    // a push loads the interrupt page and shifts the stack down
    a_push_loads_page: assert property (
        irq.push && !irq.pop && auto_page_enable
        |=> page_select_reg == $past(irq.page))
        else $error("push did not load target page");

    a_push_shifts_stack: assert property (
        irq.push && !irq.pop && auto_page_enable
        |=> page_stack_middle == $past(page_select_reg)
            && page_stack_bottom == $past(page_stack_middle))
        else $error("push did not shift stack");

    // two nested pushes keep both saved pages
    a_nested_two_levels: assert property (
        irq.push && !irq.pop && auto_page_enable
        ##1 irq.push && !irq.pop && auto_page_enable
        |=> page_stack_bottom == $past(page_select_reg, 2)
            && page_stack_middle == $past(irq.page, 2))
        else $error("nested push lost context");

    // a pop restores the page and drains the bottom
    a_pop_restores_page: assert property (
        irq.pop && !irq.push && auto_page_enable
        |=> page_select_reg == $past(page_stack_middle))
        else $error("pop did not restore page");

    a_pop_empties_bottom: assert property (
        irq.pop && !irq.push && auto_page_enable
        |=> page_stack_middle == $past(page_stack_bottom)
            && page_stack_bottom == EMPTY_PAGE)
        else $error("pop did not move bottom up");

    // push then pop returns to the page in use before
    a_push_pop_round: assert property (
        irq.push && !irq.pop && auto_page_enable
        ##1 !irq.push && !irq.pop && !cpu_req.wr
        ##1 irq.pop && !irq.push && auto_page_enable
        |=> page_select_reg == $past(page_select_reg, 3))
        else $error("round trip did not restore page");

    // with paging off the stack ignores the strobes
    a_disabled_holds_stack: assert property (
        !auto_page_enable && !cpu_req.wr
        |=> $stable(page_select_reg) && $stable(page_stack_middle)
            && $stable(page_stack_bottom))
        else $error("stack moved while paging disabled");

    // a write to the middle entry changes only that entry
    a_stack_write_only: assert property (
        cpu_req.wr && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_STK_MID && !irq.push && !irq.pop
        |=> page_stack_middle == $past(cpu_req.wdata)
            && $stable(page_select_reg) && $stable(page_stack_bottom))
        else $error("middle write disturbed stack");

    // ports answer the same whatever page is selected
    a_all_pages_port: assert property (
        cpu_req.wr && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == SFR_BASE
        |=> port_out[0] == $past(cpu_req.wdata))
        else $error("port write lost on this page");

    // a bit access off the 0x0/0x8 column is refused
    a_bit_refused: assert property (
        cpu_req.wr && cpu_req.direct && cpu_req.bit_op
        && cpu_req.addr[7] && cpu_req.addr[2:0] != 3'd0
        |=> access_fault && $stable(port_out))
        else $error("bit access on byte-only address taken");

    // an access to an empty slot changes nothing
    a_empty_no_change: assert property (
        cpu_req.wr && !dec.legal && !irq.push && !irq.pop
        |=> $stable(port_out) && $stable(page_select_reg)
            && $stable(page_stack_middle) && $stable(page_stack_bottom))
        else $error("illegal write changed state");

    // indirect accesses never reach the register space
    a_indirect_ignored: assert property (
        cpu_req.wr && !cpu_req.direct && !irq.push && !irq.pop
        |=> $stable(port_out) && $stable(page_select_reg)
            && !access_fault)
        else $error("indirect access reached registers");

    // stack entries read back one cycle after the strobe
    a_stack_readback: assert property (
        cpu_req.rd && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_STK_BOT
        |=> rdata == $past(page_stack_bottom))
        else $error("bottom entry read back wrong");

    // page writes steer the next access to the new page
    a_page_write_taken: assert property (
        cpu_req.wr && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_PAGE_SEL && !irq.push && !irq.pop
        |=> page_select_reg == $past(cpu_req.wdata))
        else $error("page select write not taken");

    // a vector on the return edge swaps the page, stack depth kept
    a_swap_keeps_stack: assert property (
        irq.push && irq.pop && auto_page_enable
        |=> page_select_reg == $past(irq.page)
            && $stable(page_stack_middle) && $stable(page_stack_bottom))
        else $error("vector on return moved the stack");

    // the control write sets or clears automatic paging
    a_ctl_write_taken: assert property (
        cpu_req.wr && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_PAGE_CTL
        |=> auto_page_enable == $past(cpu_req.wdata[AUTO_EN_BIT]))
        else $error("paging enable write not taken");

    // no strobe gives no fault and no read data
    a_idle_quiet: assert property (
        !cpu_req.wr && !cpu_req.rd
        |=> !access_fault && rdata == RD_UNDEF)
        else $error("fault or read data without a strobe");

    // the paged slots of an empty page refuse a read
    a_empty_page_read: assert property (
        cpu_req.rd && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr[7:6] == BANK_REGION && page_select_reg == 8'h04
        |=> access_fault && rdata == RD_UNDEF)
        else $error("empty page answered a read");

    // a port reads back the same on any page
    a_port_readback: assert property (
        cpu_req.rd && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == SFR_BASE
        |=> rdata == $past(port_out[0]))
        else $error("port read back wrong on this page");

    // a bottom entry write touches only that entry
    a_bottom_write_only: assert property (
        cpu_req.wr && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_STK_BOT && !irq.push && !irq.pop
        |=> page_stack_bottom == $past(cpu_req.wdata)
            && $stable(page_select_reg) && $stable(page_stack_middle))
        else $error("bottom write disturbed stack");

    // a bit write on a bit column sets the chosen bit
    a_bit_write_lands: assert property (
        cpu_req.wr && cpu_req.direct && cpu_req.bit_op
        && cpu_req.addr == SFR_BASE
        |=> port_out[0][$past(cpu_req.bit_idx)] == $past(cpu_req.wdata[0]))
        else $error("bit write did not land");

    // middle and page entries read back as registers
    a_middle_readback: assert property (
        cpu_req.rd && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_STK_MID
        |=> rdata == $past(page_stack_middle))
        else $error("middle entry read back wrong");

    a_page_readback: assert property (
        cpu_req.rd && cpu_req.direct && !cpu_req.bit_op
        && cpu_req.addr == ADDR_PAGE_SEL
        |=> rdata == $past(page_select_reg))
        else $error("page select read back wrong");

endmodule : spsc_page_unit

// ==== tb/spsc_irq_model.sv ====
// spsc_irq_model: interrupt logic in front of the paging unit.
// assumes the bench calls one task at a time; strobes last one cycle.
`timescale 1ns/1ps
module spsc_irq_model
    import spsc_pkg::*;
(
    input  wire logic           sys_clk,
    output spsc_pkg::spsc_irq_t irq
);
    int depth;

    // idle: no strobe and a page field nobody may trust
    initial begin
        irq   = '{push: 1'b0, pop: 1'b0, page: 8'h00};
        depth = 0;
    end

    // vectoring: one-cycle push with the source's page beside it
    task automatic vector_to(input logic [7:0] pg);
        @(posedge sys_clk);
        irq <= '{push: 1'b1, pop: 1'b0, page: pg};
        depth++;
        @(posedge sys_clk);
        irq <= '{push: 1'b0, pop: 1'b0, page: ~pg};
    endtask : vector_to

    // pre-emption: two vectors on back-to-back edges
    task automatic vector_nested(input logic [7:0] pg_a,
                                 input logic [7:0] pg_b);
        @(posedge sys_clk);
        irq <= '{push: 1'b1, pop: 1'b0, page: pg_a};
        @(posedge sys_clk);
        irq <= '{push: 1'b1, pop: 1'b0, page: pg_b};
        depth += 2;
        @(posedge sys_clk);
        irq <= '{push: 1'b0, pop: 1'b0, page: ~pg_b};
    endtask : vector_nested

    // a return and a new vector on one edge: depth unchanged
    task automatic vector_on_return(input logic [7:0] pg);
        @(posedge sys_clk);
        irq <= '{push: 1'b1, pop: 1'b1, page: pg};
        @(posedge sys_clk);
        irq <= '{push: 1'b0, pop: 1'b0, page: ~pg};
    endtask : vector_on_return

    // return: one-cycle pop, only while a service routine is open
    task automatic return_from_interrupt();
        if (depth > 0) begin
            @(posedge sys_clk);
            irq <= '{push: 1'b0, pop: 1'b1, page: ~irq.page};
            depth--;
            @(posedge sys_clk);
            irq <= '{push: 1'b0, pop: 1'b0, page: ~irq.page};
        end
    endtask : return_from_interrupt
endmodule : spsc_irq_model

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the paging unit against a reference.
// assumes the irq model sits beside the unit; one clock at 250 MHz.
`timescale 1ns/1ps
module tb_top;
    import spsc_pkg::*;

    logic                        sys_clk;
    logic                        rst_n;
    spsc_cpu_req_t               cpu_req;
    spsc_irq_t                   irq;
    logic [7:0]                  rdata;
    logic                        access_fault;
    logic [7:0]                  page_select_reg;
    logic [7:0]                  page_stack_middle;
    logic [7:0]                  page_stack_bottom;
    logic                        auto_page_enable;
    logic [NUM_PORTS-1:0][7:0]   port_out;
    int                          num_errors;
    int                          tests_run;
    int                          m_pg, m_mid, m_bot, m_en, dep;
    int                          m_port [4];
    int                          m_bank [int];
    int                          pages [7] = '{0, 1, 2, 3, 15, 4, 255};

    spsc_page_unit i_spsc_page_unit (
        .sys_clk           (sys_clk),
        .rst_n             (rst_n),
        .cpu_req           (cpu_req),
        .irq               (irq),
        .rdata             (rdata),
        .access_fault      (access_fault),
        .page_select_reg   (page_select_reg),
        .page_stack_middle (page_stack_middle),
        .page_stack_bottom (page_stack_bottom),
        .auto_page_enable  (auto_page_enable),
        .port_out          (port_out)
    );

    spsc_irq_model i_spsc_irq_model (
        .sys_clk (sys_clk),
        .irq     (irq)
    );

    // 4 ns clock
    initial sys_clk = 1'b0;
    always #2 sys_clk = ~sys_clk;

    task automatic give_verdict();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input int exp);
        tests_run++;
        if (got !== exp[7:0]) begin
            $display("BAD %0t got %h expected %h", $time, got, exp[7:0]);
            num_errors++;
        end
    endtask : chk

    // stack, enable and port registers against the reference
    task automatic chk_regs();
        chk(page_select_reg, m_pg);
        chk(page_stack_middle, m_mid);
        chk(page_stack_bottom, m_bot);
        chk({7'h00, auto_page_enable}, m_en);
        for (int i = 0; i < 4; i++) begin
            chk(port_out[i], m_port[i]);
        end
    endtask : chk_regs

    // one register-port cycle, reference decode, then compare
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [7:0] d, input logic dir = 1'b1,
                          input logic b = 1'b0, input logic [2:0] ix = 3'h0);
        int k, old, nv, key;
        k = 0;
        key = m_pg * 64 + a[5:0];
        if (a == 8'h84) k = 1;
        else if (a == 8'h85) k = 2;
        else if (a == 8'h86) k = 3;
        else if (a == 8'h96) k = 4;
        else if (a[7:6] == 2'b10 && a[3:0] == 4'h0) k = 5;
        else if (a[7:6] == 2'b11 && (m_pg < 4 || m_pg == 15)) k = 6;
        if (b && a[2:0] != 3'h0) k = 0;
        case (k)
            1: old = m_pg;
            2: old = m_mid;
            3: old = m_bot;
            4: old = m_en;
            5: old = m_port[a[5:4]];
            6: old = m_bank.exists(key) ? m_bank[key] : 0;
            default: old = 0;
        endcase
        nv = b ? ((old & ~(1 << ix)) | (d[0] << ix)) : d;
        if (w && dir && a[7]) begin
            case (k)
                1: m_pg = nv;
                2: m_mid = nv;
                3: m_bot = nv;
                4: m_en = nv & 1;
                5: m_port[a[5:4]] = nv;
                6: m_bank[key] = nv;
                default: ;
            endcase
        end
        @(posedge sys_clk);
        cpu_req <= '{addr: a, wdata: d, wr: w, rd: r, direct: dir,
                     bit_op: b, bit_idx: ix};
        @(posedge sys_clk);
        cpu_req.wr <= 1'b0;
        cpu_req.rd <= 1'b0;
        #1;
        if (r && dir && a[7]) chk(rdata, old);
        chk({7'h00, access_fault},
            int'((w || r) && dir && a[7] && k == 0));
        chk_regs();
    endtask : access

    // push or pop through the interrupt model, reference stack beside it
    task automatic irq_evt(input int push, input logic [7:0] p = 8'h00);
        if (push) begin
            i_spsc_irq_model.vector_to(p);
            dep++;
            if (m_en) begin
                m_bot = m_mid;
                m_mid = m_pg;
                m_pg  = p;
            end
        end else if (dep > 0) begin
            i_spsc_irq_model.return_from_interrupt();
            dep--;
            if (m_en) begin
                m_pg  = m_mid;
                m_mid = m_bot;
                m_bot = 0;
            end
        end
        #1;
        chk_regs();
    endtask : irq_evt

    // watchdog against a hung run
    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        cpu_req = '0;
        rst_n = 1'b0;
        num_errors = 0;
        tests_run = 0;
        {m_pg, m_mid, m_bot, dep} = '0;
        m_en = 1;
        m_port = '{0, 0, 0, 0};
        void'($urandom(73120));
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk_regs();
        access(0, 1, 8'h96, 8'h00);
        // same slot on every page, then read back: pages are distinct
        for (int n = 0; n < 2; n++) begin
            foreach (pages[i]) begin
                access(1, 0, 8'h84, pages[i]);
                access(n == 0, n == 1, 8'hC5, $urandom);
            end
        end
        access(1, 0, 8'h84, 8'h07);
        for (int i = 0; i < 4; i++) begin
            access(1, 0, 8'h80 + 16 * i, $urandom);
            access(0, 1, 8'h80 + 16 * i, 8'h00);
        end
        access(1, 0, 8'h80, 8'h01, 1'b1, 1'b1, 3'h5);
        access(1, 0, 8'h84, 8'h01, 1'b1, 1'b1, 3'h2);
        access(1, 0, 8'h84, 8'h02, 1'b0);
        access(1, 0, 8'h81, 8'h55);
        access(0, 1, 8'h8B, 8'h00);
        access(1, 0, 8'h84, 8'h02);
        access(1, 0, 8'hC8, 8'h01, 1'b1, 1'b1, 3'h7);
        access(1, 0, 8'hC9, 8'h01, 1'b1, 1'b1, 3'h1);
        // nested service routines and returns
        access(1, 0, 8'h84, 8'h0F);
        irq_evt(1, 8'h02);
        access(1, 0, 8'h84, 8'h01);
        irq_evt(1, 8'h00);
        irq_evt(0);
        irq_evt(0);
        irq_evt(1, 8'h03);
        access(1, 0, 8'h85, 8'h02);
        access(1, 0, 8'h86, 8'h01);
        access(0, 1, 8'h85, 8'h00);
        access(0, 1, 8'h86, 8'h00);
        irq_evt(0);
        // back-to-back vectors, then a vector on the return edge
        i_spsc_irq_model.vector_nested(8'h01, 8'h03);
        m_bot = m_pg;
        m_mid = 1;
        m_pg  = 3;
        dep  += 2;
        #1;
        chk_regs();
        i_spsc_irq_model.vector_on_return(8'h0F);
        m_pg = 15;
        #1;
        chk_regs();
        irq_evt(0);
        irq_evt(0);
        // auto paging off: strobes leave the stack alone
        access(1, 0, 8'h96, 8'h00);
        irq_evt(1, 8'h02);
        irq_evt(0);
        access(1, 0, 8'h96, 8'h01);
        // random mix of accesses and interrupt events
        for (int i = 0; i < 300; i++) begin
            case ($urandom % 4)
                0: irq_evt(dep < 2, pages[$urandom % 5]);
                1: access(1, 0, 8'h84, pages[$urandom % 7]);
                default: access($urandom % 2, 0, 8'h80 | $urandom,
                                $urandom, $urandom % 8 != 0,
                                $urandom % 3 == 0, $urandom);
            endcase
            if (i % 3 == 0) access(0, 1, 8'h80 | $urandom, 8'h00);
        end
        give_verdict();
    end
endmodule : tb_top
